// ---- hw/fxr_pkg.sv ----
package fxr_pkg;
	localparam int CHAR_W    = 7;
	localparam int CHAR_BIAS = 64;
	// sign at bit 0, characteristic bits 1..7, fraction after
	localparam int SIGN_POS  = 0;
	localparam int CHAR_MSB  = 1;
	localparam int CHAR_LSB  = 7;
	localparam logic [CHAR_W-1:0] CHAR_MAX  = 7'h7F;
	localparam logic [CHAR_W-1:0] CHAR_MIN  = 7'h00;
	localparam logic [CHAR_W-1:0] CHAR_ZERO = 7'h00;
	localparam logic               SIGN_PLUS = 1'h0;
	localparam int RESULT_LAT = 1;
	typedef enum logic [2:0] {
		FXR_OP_ADD,
		FXR_OP_SUB,
		FXR_OP_MUL,
		FXR_OP_DIV,
		FXR_OP_LOAD,
		FXR_OP_STORE,
		FXR_OP_HALVE
	} fxr_op_e;
endpackage

// ---- hw/fxr_range_check.sv ----
`timescale 1ns/1ns
// Function
// - characteristic is 7-bit excess-64, 7F=+63
// - exponent -64 encoded as all zeros
// - positive plus positive giving negative: overflow
// - negative minus positive giving positive: underflow (subtract only)
// - checks only on final result characteristic
// - detect from bit-1 carry and bit 1
// - overflow always interrupts, characteristic kept
// - underflow interrupts only when mask set
// - masked underflow replaces whole result with zero
// - true zero is zero char, fraction, plus
// - zero forcing on add and sub only, never on mul or div
// - masked significance on add/sub stores true zero
// - unmasked significance interrupts, keeps sign, characteristic
// - load, store, halve never force zero
// - zero fraction suppresses overflow and underflow
module fxr_range_check
	import fxr_pkg::*;
#(
	parameter int FRAC_W = 24
) (
	input  wire logic              clk_i,
	input  wire logic              srst_i,
	input  wire logic              final_i,
	input  wire fxr_op_e           op_i,
	input  wire logic              sign_i,
	input  wire logic [CHAR_W-1:0] char_i,
	input  wire logic              char_carry_i,
	input  wire logic [FRAC_W-1:0] frac_i,
	input  wire logic              exponent_underflow_mask_i,
	input  wire logic              significance_mask_i,
	output logic                   result_valid_o,
	output logic                   result_sign_o,
	output logic [CHAR_W-1:0]      result_char_o,
	output logic [FRAC_W-1:0]      result_frac_o,
	output logic                   ovf_req_o,
	output logic                   unf_req_o,
	output logic                   sig_req_o
);

	// a fraction needs at least one bit to test for zero
	if (FRAC_W < 1) begin : g_frac_w_bad
		$error("FRAC_W must be at least 1");
	end

	////////////////////////////////////////////////////////////////////
	logic is_addsub;
	logic is_arith;
	logic frac_zero;
	logic char_bit1;
	logic ovf_raw;
	logic unf_raw;
	logic ovf_hit;
	logic unf_hit;
	logic sig_hit;
	logic force_zero;

	assign is_addsub = (op_i == FXR_OP_ADD) || (op_i == FXR_OP_SUB);
	assign is_arith  = is_addsub || (op_i == FXR_OP_MUL) || (op_i == FXR_OP_DIV);
	assign frac_zero = (frac_i == '0);
	assign char_bit1 = char_i[CHAR_W-1];
	assign ovf_raw   = char_carry_i && !char_bit1 && op_i != FXR_OP_SUB;
	assign unf_raw   = !char_carry_i && char_bit1 && op_i == FXR_OP_SUB;
	assign ovf_hit   = final_i && is_arith && ovf_raw && !frac_zero;
	assign unf_hit   = final_i && is_arith && unf_raw && !frac_zero;
	assign sig_hit   = final_i && is_addsub && frac_zero;
	assign force_zero = (unf_hit && !exponent_underflow_mask_i)
		|| (sig_hit && !significance_mask_i);

	////////////////////////////////////////////////////////////////////
	// one-cycle registered requests
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ovf_req_o <= 1'b0;
			unf_req_o <= 1'b0;
			sig_req_o <= 1'b0;
		end else begin
			ovf_req_o <= ovf_hit;
			unf_req_o <= unf_hit && exponent_underflow_mask_i;
			sig_req_o <= sig_hit && significance_mask_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			result_valid_o <= 1'b0;
			result_sign_o  <= SIGN_PLUS;
			result_char_o  <= CHAR_ZERO;
			result_frac_o  <= '0;
		end else begin
			result_valid_o <= final_i;
			if (final_i) begin
				if (force_zero && is_arith) begin
					result_sign_o <= SIGN_PLUS;
					result_char_o <= CHAR_ZERO;
					result_frac_o <= '0;
				end else begin
					result_sign_o <= sign_i;
					result_char_o <= char_i;
					result_frac_o <= frac_i;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	sequence ovf_cause_s;
		final_i && is_arith && char_carry_i && !char_bit1 && op_i != FXR_OP_SUB
			&& frac_i != '0;
	endsequence

	sequence unf_masked_s;
		final_i && is_arith && op_i == FXR_OP_SUB && !char_carry_i && char_bit1
			&& frac_i != '0 && !exponent_underflow_mask_i;
	endsequence

	sequence unf_kept_s;
		final_i && op_i == FXR_OP_SUB && !char_carry_i && char_bit1
			&& frac_i != '0 && exponent_underflow_mask_i;
	endsequence

	sequence sig_kept_s;
		final_i && is_addsub && frac_zero && significance_mask_i;
	endsequence

	sequence sig_masked_s;
		final_i && is_addsub && frac_zero && !significance_mask_i;
	endsequence

	// results that are not zeroed must pass untouched
	sequence plain_pass_s;
		final_i && !force_zero;
	endsequence

	sequence idle_s;
		!final_i;
	endsequence

	ovf_unmasked_a: assert property (@(posedge clk_i) disable iff (srst_i)
		ovf_cause_s
		|=> ovf_req_o && result_char_o == $past(char_i))
		else $error("overflow not reported or characteristic altered");

	unf_request_a: assert property (@(posedge clk_i) disable iff (srst_i)
		unf_kept_s
		|=> unf_req_o && result_char_o == $past(char_i))
		else $error("underflow request missing");

	unf_zero_a: assert property (@(posedge clk_i) disable iff (srst_i)
		unf_masked_s |=> !unf_req_o && result_char_o == CHAR_ZERO
			&& result_frac_o == '0 && result_sign_o == SIGN_PLUS)
		else $error("masked underflow not zeroed");

	sig_keep_a: assert property (@(posedge clk_i) disable iff (srst_i)
		sig_kept_s |=> sig_req_o
			&& result_sign_o == $past(sign_i) && result_char_o == $past(char_i))
		else $error("significance result wrong");

	sig_zero_a: assert property (@(posedge clk_i) disable iff (srst_i)
		sig_masked_s |=> !sig_req_o && result_sign_o == SIGN_PLUS
			&& result_char_o == CHAR_ZERO)
		else $error("masked significance not zeroed");

	// no forcing on load store halve
	no_force_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(final_i && !is_arith) |=> result_char_o == $past(char_i)
			&& result_sign_o == $past(sign_i) && !sig_req_o && !ovf_req_o)
		else $error("non-arithmetic result altered");

	zero_frac_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(final_i && frac_zero)
		|=> !ovf_req_o && !unf_req_o)
		else $error("range fault on zero fraction");

	inter_quiet_a: assert property (@(posedge clk_i) disable iff (srst_i)
		idle_s
		|=> !ovf_req_o && !unf_req_o && !sig_req_o && !result_valid_o)
		else $error("request without final result");

	// overflow request only after a final
	req_pulse_a: assert property (@(posedge clk_i) disable iff (srst_i)
		ovf_req_o
		|-> $past(final_i))
		else $error("overflow request without final result");

	char_top_a: assert property (@(posedge clk_i) disable iff (srst_i)
		plain_pass_s ##0 (char_i == CHAR_MAX)
		|=> result_char_o == CHAR_MAX)
		else $error("largest characteristic altered");

	char_bottom_a: assert property (@(posedge clk_i) disable iff (srst_i)
		plain_pass_s ##0 (char_i == CHAR_MIN)
		|=> result_char_o == CHAR_MIN)
		else $error("smallest characteristic altered");

	sign_pass_a: assert property (@(posedge clk_i) disable iff (srst_i)
		plain_pass_s
		|=> result_sign_o == $past(sign_i) && result_char_o == $past(char_i))
		else $error("sign or characteristic mixed up");

	add_ovf_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(final_i && op_i == FXR_OP_ADD && char_carry_i && !char_bit1 && !frac_zero)
		|=> ovf_req_o)
		else $error("add overflow missed");

	sub_unf_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(final_i && op_i == FXR_OP_SUB && !char_carry_i && char_bit1 && !frac_zero)
		|=> unf_req_o == $past(exponent_underflow_mask_i))
		else $error("subtract underflow missed");

	bit1_no_ovf_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(final_i && char_bit1)
		|=> !ovf_req_o)
		else $error("overflow with bit 1 set");

	carry_no_unf_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(final_i && char_carry_i)
		|=> !unf_req_o)
		else $error("underflow with carry out");

	ovf_nomask_a: assert property (@(posedge clk_i) disable iff (srst_i)
		ovf_cause_s ##0 (!exponent_underflow_mask_i && !significance_mask_i)
		|=> ovf_req_o && result_frac_o == $past(frac_i))
		else $error("overflow hidden by masks");

	unf_gate_a: assert property (@(posedge clk_i) disable iff (srst_i)
		unf_req_o
		|-> $past(exponent_underflow_mask_i) && $past(final_i))
		else $error("underflow request while masked");

	// unmasked underflow keeps fraction and sign
	unf_frac_keep_a: assert property (@(posedge clk_i) disable iff (srst_i)
		unf_kept_s
		|=> result_frac_o == $past(frac_i) && result_sign_o == $past(sign_i))
		else $error("underflow result altered");

	// forced result is a true zero
	true_zero_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(result_valid_o && $past(force_zero))
		|-> result_char_o == CHAR_ZERO && result_sign_o == SIGN_PLUS && result_frac_o == '0)
		else $error("forced result not a true zero");

	// multiply and divide zero fraction not forced
	muldiv_frac_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(final_i && frac_zero && (op_i == FXR_OP_MUL || op_i == FXR_OP_DIV))
		|=> result_char_o == $past(char_i) && !sig_req_o)
		else $error("multiply or divide zero fraction altered");

	sig_frac_a: assert property (@(posedge clk_i) disable iff (srst_i)
		sig_kept_s
		|=> result_frac_o == '0)
		else $error("significance fraction not zero");

	sig_gate_a: assert property (@(posedge clk_i) disable iff (srst_i)
		sig_req_o
		|-> $past(significance_mask_i) && $past(is_addsub))
		else $error("significance request while masked");

	// every final gives a valid pulse
	valid_pulse_a: assert property (@(posedge clk_i) disable iff (srst_i)
		final_i
		|=> result_valid_o)
		else $error("result valid missing");

	// other requests only after a final
	req_follow_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(unf_req_o || sig_req_o)
		|-> $past(final_i))
		else $error("request without final result");

	hold_data_a: assert property (@(posedge clk_i) disable iff (srst_i)
		idle_s |=> $stable(result_sign_o) && $stable(result_char_o)
			&& $stable(result_frac_o))
		else $error("result changed without final");

	// at most one request per result
	req_onehot_a: assert property (@(posedge clk_i) disable iff (srst_i)
		$onehot0({ovf_req_o, unf_req_o, sig_req_o}))
		else $error("several requests at once");
endmodule

// ---- dv/fxr_partner.sv ----
`timescale 1ns/1ns
module fxr_partner
	import fxr_pkg::*;
#(
	parameter int FRAC_W = 24
) (
	input  wire logic              clk_i,
	input  wire logic              go_i,
	input  wire fxr_op_e           op_i,
	input  wire logic [8:0]        flag_i,
	input  wire logic [CHAR_W-1:0] char_i,
	input  wire logic [FRAC_W-1:0] frac_i,
	output fxr_op_e                op_o = FXR_OP_ADD,
	output logic                   final_o = 1'h0,
	output logic [8:0]             flag_o = 9'h000,
	output logic [CHAR_W-1:0]      char_o = 7'h00,
	output logic [FRAC_W-1:0]      frac_o = '0
);
	// flag bits: carry, sign, underflow mask, significance mask
	always @(posedge clk_i) begin
		final_o <= go_i;
		if (go_i) begin
			op_o   <= op_i;
			flag_o <= flag_i;
			char_o <= char_i;
			frac_o <= frac_i;
		end else begin
			// idle flag, char and frac toggle so stale data never looks valid; op holds
			flag_o <= ~flag_o;
			char_o <= ~char_o;
			frac_o <= ~frac_o;
		end
	end
endmodule

// ---- dv/fxr_range_check_tb.sv ----
`timescale 1ns/1ns
module fxr_range_check_tb;
	import fxr_pkg::*;
	localparam int FW = 24;
	logic clk_i = 0, srst_i = 1, go = 0, fin, rv, rs, ov, un, sg;
	fxr_op_e t_op = FXR_OP_ADD, p_op;
	logic [8:0] t_fl = 0, p_fl;
	logic [6:0] t_c = 0, p_c, rc, c;
	logic [FW-1:0] t_f = 0, p_f, rf;
	logic [34:0] expq[$], e;
	logic [6:0] corner[4] = '{7'h7F, 7'h00, 7'h40, 7'h3F};
	int failures = 0, comparisons = 0, k;
	fxr_partner #(.FRAC_W(FW)) fxr_partner_i (.clk_i(clk_i), .go_i(go), .op_i(t_op),
		.flag_i(t_fl), .char_i(t_c), .frac_i(t_f), .op_o(p_op), .final_o(fin),
		.flag_o(p_fl), .char_o(p_c), .frac_o(p_f));
	fxr_range_check #(.FRAC_W(FW)) fxr_range_check_i (.clk_i(clk_i), .srst_i(srst_i),
		.final_i(fin), .op_i(p_op), .sign_i(p_fl[1]), .char_i(p_c), .char_carry_i(p_fl[0]),
		.frac_i(p_f), .exponent_underflow_mask_i(p_fl[2]), .significance_mask_i(p_fl[3]),
		.result_valid_o(rv), .result_sign_o(rs), .result_char_o(rc), .result_frac_o(rf),
		.ovf_req_o(ov), .unf_req_o(un), .sig_req_o(sg));
	initial forever #4 clk_i = ~clk_i;
	function automatic logic [34:0] expect_of(fxr_op_e op, logic [3:0] fl, logic [6:0] ch,
		logic [FW-1:0] f);
		logic rng, fz, o, u, s, z;
		rng = op inside {FXR_OP_ADD, FXR_OP_SUB, FXR_OP_MUL, FXR_OP_DIV};
		fz = (f == '0);
		o = rng && op != FXR_OP_SUB && fl[0] && !ch[6] && !fz;
		u = rng && op == FXR_OP_SUB && !fl[0] && ch[6] && !fz;
		s = (op inside {FXR_OP_ADD, FXR_OP_SUB}) && fz;
		z = (u && !fl[2]) || (s && !fl[3]);
		return {o, u && fl[2], s && fl[3], z ? {SIGN_PLUS, CHAR_ZERO, {FW{1'b0}}} : {fl[1], ch, f}};
	endfunction
	task automatic check(string n, logic [35:0] seen, logic [35:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic issue(fxr_op_e op, logic [3:0] fl, logic [6:0] ch, logic [FW-1:0] f);
		@(posedge clk_i);
		go <= 1;
		t_op <= op;
		t_fl <= {5'h00, fl};
		t_c <= ch;
		t_f <= f;
		expq.push_back(expect_of(op, fl, ch, f));
	endtask
	task automatic give_verdict();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk_i) begin
		if (srst_i !== 1'b0) begin
		end else if (rv === 1'b1) begin
			if (expq.size() == 0) check("spare", 1, 0);
			else begin
				e = expq.pop_front();
				check("requests", {ov, un, sg}, e[34:32]);
				check("result", {rs, rc, rf}, e[31:0]);
			end
		end else check("idle", {ov, un, sg}, 0);
	end
	initial begin
		#(8 * 5000);
		failures++;
		give_verdict();
	end
	initial begin
		void'($urandom(32'h30641d3c));
		repeat (3) @(posedge clk_i);
		srst_i <= 0;
		@(posedge clk_i);
		check("reset", {rv, ov, un, sg, rs, rc, rf}, 0);
		// corners first: +63 carry, -64 borrow, every op and mask pair
		for (int i = 0; i < 900; i++) begin
			k = (i < 448) ? i / 7 : $urandom;
			c = (i < 448) ? corner[k % 4] : 7'($urandom);
			issue(fxr_op_e'(i % 7), {k[5:4], 1'($urandom), k[2]}, c,
				k[3] ? '0 : (FW'($urandom) | 1));
			if ($urandom % 3 == 0) @(posedge clk_i) go <= 0;
		end
		@(posedge clk_i) go <= 0;
		repeat (4) @(posedge clk_i);
		check("drain", expq.size(), 0);
		give_verdict();
	end
endmodule
